// ### inc/gated_timer_pkg.sv
// Package for the gated 16-bit timer: register map, fields, reset values
package gated_timer_pkg;
  // ==========================================================
  // Register byte addresses
  localparam logic [11:0] ADDR_TIMER_CONTROL = 12'h000;
  localparam logic [11:0] ADDR_TIMER_GATE_CONTROL = 12'h004;
  localparam logic [11:0] ADDR_COUNT_LOW = 12'h008;
  localparam logic [11:0] ADDR_COUNT_HIGH = 12'h00c;
  localparam logic [11:0] ADDR_FLAGS = 12'h010;
  localparam logic [11:0] ADDR_IRQ_ENABLE = 12'h014;
  localparam logic [11:0] ADDR_CAPCMP_LOW = 12'h018;
  localparam logic [11:0] ADDR_CAPCMP_HIGH = 12'h01c;
  // ==========================================================
  // Field positions
  localparam int CTL_ON_BIT = 0;
  localparam int CTL_CS_BIT = 1;
  localparam int CTL_PS_LSB = 4;
  localparam int GC_SS_LSB = 0;
  localparam int GC_VAL_BIT = 2;
  localparam int GC_GO_BIT = 3;
  localparam int GC_SPM_BIT = 4;
  localparam int GC_TM_BIT = 5;
  localparam int GC_POL_BIT = 6;
  localparam int GC_GE_BIT = 7;
  localparam int FL_OVF_BIT = 0;
  localparam int FL_GATE_BIT = 1;
  // ==========================================================
  // Reset values and constants
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [7:0] EIGHT_MAX = 8'hff;
  localparam logic [1:0] INSTR_DIV = 2'h3;
  localparam logic [1:0] SRC_PIN_A = 2'h0;
  localparam logic [1:0] SRC_OVF8 = 2'h1;
  localparam logic [1:0] SRC_PIN_B = 2'h2;
  localparam logic [1:0] SRC_UV = 2'h3;

  typedef struct packed {
    logic timerOn;
    logic clockSourceSel;
    logic [1:0] prescaleSel;
    logic gateCountEn;
    logic gatePolarity;
    logic gateToggleEn;
    logic gateSinglePulseEn;
    logic singlePulseGoDone;
    logic [1:0] gateSourceSel;
  } ctrl_t;

  typedef struct packed {
    logic gateEventFlag;
    logic overflowFlag;
    logic gateEventIrqEn;
    logic overflowIrqEn;
  } flags_t;
endpackage

// ### src/gated_timer_sixteen_bit.sv
// Gated 16-bit timer with APB register access
`timescale 1ns/1ps
`default_nettype none

module gated_timer_sixteen_bit
  import gated_timer_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic gatePinA,
  input wire logic gatePinB,
  input wire logic eightBitTimerWrap,
  input wire logic uvComparator,
  input wire logic captureEvent,
  input wire logic compareModeEn,
  input wire logic specialEventTrigger,
  output logic compareMatch,
  output logic [15:0] count,
  output logic irq
);

  // ==========================================================
  // State
  typedef struct packed {
    ctrl_t ctl;
    flags_t fl;
    logic [15:0] count;
    logic [15:0] capcmp;
    logic [2:0] preCnt;
    logic [1:0] instrCnt;
    logic toggleFf;
    logic gateSrcPrev;
    logic gateValPrev;
    logic spArmed;
    logic spRunning;
    logic uvHalt;
    logic uvPrev;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic compareMatch;
    logic irq;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  function automatic logic [2:0] divMask(input logic [1:0] sel);
    case (sel)
      2'h0: divMask = 3'h0;
      2'h1: divMask = 3'h1;
      2'h2: divMask = 3'h3;
      default: divMask = 3'h7;
    endcase
  endfunction

  logic gateSrc;
  logic gateVal;
  logic baseTick;
  logic preTick;
  logic gateActive;
  logic countEn;
  logic wrLow;
  logic wrHigh;
  logic access;
  logic [7:0] ctlRd;
  logic [7:0] gcRd;

  // ==========================================================
  // Gate path
  always_comb begin
    case (st_r.ctl.gateSourceSel)
      SRC_PIN_A: gateSrc = gatePinA;
      SRC_OVF8: gateSrc = eightBitTimerWrap;
      SRC_PIN_B: gateSrc = gatePinB;
      default: gateSrc = ~st_r.uvHalt;
    endcase
    // Toggle output, then polarity; a low polarity means active when gate low
    gateVal = (st_r.ctl.gateToggleEn ? st_r.toggleFf : gateSrc)
              ^ ~st_r.ctl.gatePolarity;
  end

  always_comb begin
    baseTick = st_r.ctl.clockSourceSel | (st_r.instrCnt == INSTR_DIV);
    preTick = baseTick & ((st_r.preCnt & divMask(st_r.ctl.prescaleSel)) ==
              divMask(st_r.ctl.prescaleSel));
    if (st_r.ctl.gateSinglePulseEn)
      gateActive = gateVal & st_r.spRunning;
    else
      gateActive = gateVal;
    countEn = st_r.ctl.timerOn & (~st_r.ctl.gateCountEn | gateActive);
    access = psel & penable;
    wrLow = access & pwrite & (paddr == ADDR_COUNT_LOW);
    wrHigh = access & pwrite & (paddr == ADDR_COUNT_HIGH);
    ctlRd = 8'h00;
    ctlRd[CTL_ON_BIT] = st_r.ctl.timerOn;
    ctlRd[CTL_CS_BIT] = st_r.ctl.clockSourceSel;
    ctlRd[CTL_PS_LSB +: 2] = st_r.ctl.prescaleSel;
    gcRd = 8'h00;
    gcRd[GC_SS_LSB +: 2] = st_r.ctl.gateSourceSel;
    gcRd[GC_VAL_BIT] = gateVal;
    gcRd[GC_GO_BIT] = st_r.ctl.singlePulseGoDone;
    gcRd[GC_SPM_BIT] = st_r.ctl.gateSinglePulseEn;
    gcRd[GC_TM_BIT] = st_r.ctl.gateToggleEn;
    gcRd[GC_POL_BIT] = st_r.ctl.gatePolarity;
    gcRd[GC_GE_BIT] = st_r.ctl.gateCountEn;
  end

  // ==========================================================
  // Next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.instrCnt = st_r.instrCnt + 2'h1;
    st_nxt.gateSrcPrev = gateSrc;
    st_nxt.gateValPrev = gateVal;
    st_nxt.uvPrev = uvComparator;
    // Comparator rise latches a halt; software restarts by reselecting the source
    if (st_r.ctl.gateSourceSel != SRC_UV)
      st_nxt.uvHalt = 1'b0;
    else if (uvComparator & ~st_r.uvPrev)
      st_nxt.uvHalt = 1'b1;

    // Toggle flip-flop
    if (~st_r.ctl.gateToggleEn | ~st_r.ctl.timerOn)
      st_nxt.toggleFf = 1'b0;
    else if (gateSrc & ~st_r.gateSrcPrev)
      st_nxt.toggleFf = ~st_r.toggleFf;

    // Single pulse sequencing
    if (st_r.spArmed & gateVal & ~st_r.gateValPrev) begin
      st_nxt.spArmed = 1'b0;
      st_nxt.spRunning = 1'b1;
    end
    if (st_r.spRunning & ~gateVal & st_r.gateValPrev) begin
      st_nxt.spRunning = 1'b0;
      st_nxt.ctl.singlePulseGoDone = 1'b0;
    end

    // Gate event flag on falling gate level, independent of gate enable
    if (~gateVal & st_r.gateValPrev)
      st_nxt.fl.gateEventFlag = 1'b1;

    // Counting
    if (st_r.ctl.timerOn & baseTick)
      st_nxt.preCnt = st_r.preCnt + 3'h1;
    if (countEn & preTick) begin
      st_nxt.count = st_r.count + 16'h0001;
      if (st_r.count == COUNT_MAX)
        st_nxt.fl.overflowFlag = 1'b1;
    end
    if (specialEventTrigger)
      st_nxt.count = COUNT_RESET;
    if (captureEvent)
      st_nxt.capcmp = st_r.count;
    st_nxt.compareMatch = compareModeEn & (st_r.count == st_r.capcmp);

    // APB: zero-wait slave
    st_nxt.pready = psel & ~penable;
    st_nxt.pslverr = 1'b0;
    st_nxt.prdata = 32'h0000_0000;
    if (psel & ~penable & ~pwrite) begin
      case (paddr)
        ADDR_TIMER_CONTROL: st_nxt.prdata = {24'h0, ctlRd};
        ADDR_TIMER_GATE_CONTROL: st_nxt.prdata = {24'h0, gcRd};
        ADDR_COUNT_LOW: st_nxt.prdata = {24'h0, st_r.count[7:0]};
        ADDR_COUNT_HIGH: st_nxt.prdata = {24'h0, st_r.count[15:8]};
        ADDR_FLAGS: st_nxt.prdata = {30'h0, st_r.fl.gateEventFlag, st_r.fl.overflowFlag};
        ADDR_IRQ_ENABLE: st_nxt.prdata = {30'h0, st_r.fl.gateEventIrqEn,
                                          st_r.fl.overflowIrqEn};
        ADDR_CAPCMP_LOW: st_nxt.prdata = {24'h0, st_r.capcmp[7:0]};
        ADDR_CAPCMP_HIGH: st_nxt.prdata = {24'h0, st_r.capcmp[15:8]};
        default: st_nxt.pslverr = 1'b1;
      endcase
    end
    if (psel & ~penable & pwrite) begin
      case (paddr)
        ADDR_TIMER_CONTROL, ADDR_TIMER_GATE_CONTROL, ADDR_COUNT_LOW, ADDR_COUNT_HIGH,
        ADDR_FLAGS, ADDR_IRQ_ENABLE, ADDR_CAPCMP_LOW, ADDR_CAPCMP_HIGH:
          st_nxt.pslverr = 1'b0;
        default: st_nxt.pslverr = 1'b1;
      endcase
    end
    if (access & pwrite & st_r.pready) begin
      case (paddr)
        ADDR_TIMER_CONTROL: begin
          st_nxt.ctl.timerOn = pwdata[CTL_ON_BIT];
          st_nxt.ctl.clockSourceSel = pwdata[CTL_CS_BIT];
          st_nxt.ctl.prescaleSel = pwdata[CTL_PS_LSB +: 2];
        end
        ADDR_TIMER_GATE_CONTROL: begin
          st_nxt.ctl.gateSourceSel = pwdata[GC_SS_LSB +: 2];
          st_nxt.ctl.gateSinglePulseEn = pwdata[GC_SPM_BIT];
          st_nxt.ctl.gateToggleEn = pwdata[GC_TM_BIT];
          st_nxt.ctl.gatePolarity = pwdata[GC_POL_BIT];
          st_nxt.ctl.gateCountEn = pwdata[GC_GE_BIT];
          if (pwdata[GC_GO_BIT] & pwdata[GC_SPM_BIT]) begin
            st_nxt.ctl.singlePulseGoDone = 1'b1;
            st_nxt.spArmed = 1'b1;
            st_nxt.spRunning = 1'b0;
          end
          if (~pwdata[GC_SPM_BIT]) begin
            st_nxt.ctl.singlePulseGoDone = 1'b0;
            st_nxt.spArmed = 1'b0;
            st_nxt.spRunning = 1'b0;
          end
        end
        ADDR_COUNT_LOW: begin
          st_nxt.count[7:0] = pwdata[7:0];
          st_nxt.preCnt = 3'h0;
        end
        ADDR_COUNT_HIGH: begin
          st_nxt.count[15:8] = pwdata[7:0];
          st_nxt.preCnt = 3'h0;
        end
        // Write one to clear; a same-cycle hardware set wins unless the overflow flag was already set
        ADDR_FLAGS: begin
          if (pwdata[FL_OVF_BIT] & ~(st_nxt.fl.overflowFlag & ~st_r.fl.overflowFlag))
            st_nxt.fl.overflowFlag = 1'b0;
          if (pwdata[FL_GATE_BIT] & ~(~gateVal & st_r.gateValPrev))
            st_nxt.fl.gateEventFlag = 1'b0;
        end
        ADDR_IRQ_ENABLE: begin
          st_nxt.fl.overflowIrqEn = pwdata[FL_OVF_BIT];
          st_nxt.fl.gateEventIrqEn = pwdata[FL_GATE_BIT];
        end
        ADDR_CAPCMP_LOW: st_nxt.capcmp[7:0] = pwdata[7:0];
        ADDR_CAPCMP_HIGH: st_nxt.capcmp[15:8] = pwdata[7:0];
        default: st_nxt.pslverr = 1'b0;
      endcase
    end
    if (access & st_r.pready)
      st_nxt.pslverr = 1'b0;
    st_nxt.irq = (st_nxt.fl.gateEventFlag & st_nxt.fl.gateEventIrqEn) |
                 (st_nxt.fl.overflowFlag & st_nxt.fl.overflowIrqEn);
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk) begin
    if (reset)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign compareMatch = st_r.compareMatch;
  assign count = st_r.count;
  assign irq = st_r.irq;

  // ==========================================================
  // Checks
  a_overflow_sets: assert property (@(posedge clk) disable iff (reset)
    (countEn & preTick & st_r.count == COUNT_MAX & ~specialEventTrigger & ~wrLow & ~wrHigh)
    |=> (st_r.fl.overflowFlag & st_r.count == COUNT_RESET))
    else $error("overflow flag not set on wrap");
  a_sev_clears: assert property (@(posedge clk) disable iff (reset)
    (specialEventTrigger & ~(wrLow & st_r.pready) & ~(wrHigh & st_r.pready)) |=>
    (st_r.count == COUNT_RESET))
    else $error("special trigger did not clear count");
  a_sev_no_flag: assert property (@(posedge clk) disable iff (reset)
    (specialEventTrigger & ~st_r.fl.overflowFlag & ~(countEn & preTick)) |=>
    ~st_r.fl.overflowFlag)
    else $error("special trigger set overflow");
  a_write_wins: assert property (@(posedge clk) disable iff (reset)
    (wrLow & st_r.pready & specialEventTrigger) |=> (st_r.count[7:0] == $past(pwdata[7:0])))
    else $error("count write lost to trigger");
  a_toggle_clear: assert property (@(posedge clk) disable iff (reset)
    ~st_r.ctl.gateToggleEn |=> ~st_r.toggleFf)
    else $error("toggle flip-flop not held clear");
  a_off_hold: assert property (@(posedge clk) disable iff (reset)
    (~st_r.ctl.timerOn & ~specialEventTrigger & ~wrLow & ~wrHigh) |=> $stable(st_r.count))
    else $error("count moved while off");
  a_gate_hold: assert property (@(posedge clk) disable iff (reset)
    (st_r.ctl.gateCountEn & ~gateActive & ~specialEventTrigger & ~wrLow & ~wrHigh)
    |=> $stable(st_r.count))
    else $error("count moved with gate inactive");
  a_gate_flag: assert property (@(posedge clk) disable iff (reset)
    (~gateVal & st_r.gateValPrev) |=> st_r.fl.gateEventFlag)
    else $error("gate event flag missed");
  a_spm_clear: assert property (@(posedge clk) disable iff (reset)
    ~st_r.ctl.gateSinglePulseEn |-> ~st_r.ctl.singlePulseGoDone)
    else $error("go/done set without single pulse");
  // A same-cycle control write may pick a faster rate, so it is left out
  a_prescale_div: assert property (@(posedge clk) disable iff (reset)
    (st_r.ctl.prescaleSel == 2'h3 & preTick & ~wrLow & ~wrHigh &
     ~(access & pwrite & (paddr == ADDR_TIMER_CONTROL))) |=> ~preTick)
    else $error("prescaler ticked too soon");

endmodule // gated_timer_sixteen_bit

`default_nettype wire

// ### tb/far_side_model.sv
// Far-side model: eight-bit timer wrap source and special event generator
`timescale 1ns/1ps
`default_nettype none
module far_side_model #(
  parameter logic [7:0] STEP = 8'h10
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic wrapRun,
  input wire logic compareMatch,
  input wire logic setEn,
  input wire logic setForce,
  output logic eightBitTimerWrap,
  output logic specialEventTrigger
);
  logic [7:0] wrapCount_r;
  // ==========================================================
  // Eight-bit timer, stepping by STEP so a wrap comes every few cycles
  always_ff @(posedge clk) begin
    if (reset) begin
      wrapCount_r <= 8'h00;
    end else if (wrapRun) begin
      wrapCount_r <= wrapCount_r + STEP;
    end
  end
  // One-cycle pulse in the cycle whose edge rolls the count over to zero
  assign eightBitTimerWrap = wrapRun && (wrapCount_r == 8'hff - STEP + 8'h01);
  // ==========================================================
  // Special event: on a compare match, or forced by the bench to collide with a write
  assign specialEventTrigger = setForce || (setEn && compareMatch);
endmodule // far_side_model
`default_nettype wire

// ### tb/gated_timer_sixteen_bit_tb.sv
// Testbench for the gated sixteen-bit timer
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin error_cnt++; \
  $display("MISMATCH %0t got %0h exp %0h", $time, (a), (b)); end end
module gated_timer_sixteen_bit_tb;
  import gated_timer_pkg::*;
  logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err, v;
  logic pinA = 0, pinB = 0, wrapRun = 0, uv = 0, cap = 0, cmpEn = 0, setEn = 0, setForce = 0;
  logic match, irq, wrap, set;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] count, c0;
  int error_cnt = 0, compares = 0, cyc = 0;
  gated_timer_sixteen_bit gated_timer_sixteen_bit_i (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .gatePinA(pinA), .gatePinB(pinB),
    .eightBitTimerWrap(wrap), .uvComparator(uv), .captureEvent(cap), .compareModeEn(cmpEn),
    .specialEventTrigger(set), .compareMatch(match), .count(count), .irq(irq));
  far_side_model far_side_model_i (.clk(clk), .reset(reset), .wrapRun(wrapRun),
    .compareMatch(match), .setEn(setEn), .setForce(setForce), .eightBitTimerWrap(wrap),
    .specialEventTrigger(set));
  // ==========================================================
  // Clock, timeout and closing report
  initial begin
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 10000) begin
      error_cnt++;
      $display("MISMATCH %0t timeout", $time);
      end_sim();
    end
  end
  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ==========================================================
  // APB master; s raises the forced special event during the access cycle
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d, input logic s);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    setForce <= s;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    setForce <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d, 1'b0);
  endtask
  task automatic rdChk(input logic [11:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0, 1'b0);
    `CHK(rd, e)
  endtask
  task automatic delta(input logic [15:0] e);
    tick(4);
    c0 = count;
    tick(20);
    `CHK(count - c0, e)
  endtask
  // ==========================================================
  // Tests
  initial begin
    tick(2);
    reset <= 1'b0;
    rdChk(ADDR_TIMER_CONTROL, 32'h0);
    rdChk(ADDR_TIMER_GATE_CONTROL, 32'h4);
    rdChk(ADDR_FLAGS, 32'h0);
    `CHK(count, 16'h0)
    rdChk(12'h020, 32'h0);
    `CHK(err, 1'b1)
    $display("test reset done");
    // Exact counts over a window that is a multiple of every period
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_TIMER_CONTROL, 32'h1 | (i[0] << 1) | (i[2:1] << 4));
      tick(2);
      c0 = count;
      tick(256);
      `CHK(count - c0, 16'(256 / ((i[0] ? 1 : 4) << i[2:1])))
    end
    wr(ADDR_TIMER_CONTROL, 32'h0);
    delta(16'h0);
    $display("test rates done");
    wr(ADDR_TIMER_CONTROL, 32'h3);
    for (int j = 0; j < 4; j++) begin
      wr(ADDR_TIMER_GATE_CONTROL, 32'h80 | (j[0] << 6) | (j[1] << 1));
      for (int a = 1; a >= 0; a--) begin
        v = a[0] ~^ j[0];
        pinA <= j[1] ? ~v : v;
        pinB <= j[1] ? v : ~v;
        delta(a[0] ? 16'h14 : 16'h0);
        rdChk(ADDR_TIMER_GATE_CONTROL, 32'h80 | (j[0] << 6) | (j[1] << 1) | (a << 2));
      end
    end
    wrapRun <= 1'b1;
    wr(ADDR_TIMER_GATE_CONTROL, 32'hc1);
    tick(4);
    c0 = count;
    tick(256);
    `CHK(count - c0, 16'h10)
    wrapRun <= 1'b0;
    wr(ADDR_TIMER_GATE_CONTROL, 32'hc3);
    uv <= 1'b1;
    delta(16'h0);
    $display("test gate sources done");
    // Flag with gate control off, then mask and clear
    wr(ADDR_TIMER_GATE_CONTROL, 32'h40);
    uv <= 1'b0;
    pinA <= 1'b0;
    tick(3);
    wr(ADDR_FLAGS, 32'h3);
    pinA <= 1'b1;
    tick(4);
    pinA <= 1'b0;
    tick(4);
    rdChk(ADDR_FLAGS, 32'h2);
    `CHK(irq, 1'b0)
    wr(ADDR_IRQ_ENABLE, 32'h2);
    tick(2);
    `CHK(irq, 1'b1)
    wr(ADDR_FLAGS, 32'h2);
    rdChk(ADDR_FLAGS, 32'h0);
    wr(ADDR_IRQ_ENABLE, 32'h1);
    wr(ADDR_COUNT_HIGH, 32'hff);
    wr(ADDR_COUNT_LOW, 32'hf0);
    tick(30);
    rdChk(ADDR_FLAGS, 32'h1);
    `CHK(irq, 1'b1)
    tick(20);
    rdChk(ADDR_FLAGS, 32'h1);
    wr(ADDR_FLAGS, 32'h1);
    rdChk(ADDR_FLAGS, 32'h0);
    $display("test flags done");
    // Compare match, then the match used as the period
    wr(ADDR_CAPCMP_LOW, 32'h20);
    wr(ADDR_CAPCMP_HIGH, 32'h0);
    wr(ADDR_COUNT_HIGH, 32'h0);
    wr(ADDR_COUNT_LOW, 32'h0);
    cmpEn <= 1'b1;
    // Trigger armed before the first match, so the first match already ends the period
    setEn <= 1'b1;
    for (int k = 0; k < 100 && match !== 1'b1; k++) @(posedge clk);
    `CHK(count, 16'h21)
    tick(200);
    `CHK(count <= 16'h22, 1'b1)
    rdChk(ADDR_FLAGS, 32'h0);
    setEn <= 1'b0;
    cmpEn <= 1'b0;
    wr(ADDR_TIMER_CONTROL, 32'h0);
    xfer(ADDR_COUNT_LOW, 1'b1, 32'h5a, 1'b1);
    tick(1);
    `CHK(count[7:0], 8'h5a)
    wr(ADDR_COUNT_HIGH, 32'h12);
    cap <= 1'b1;
    tick(1);
    cap <= 1'b0;
    tick(2);
    rdChk(ADDR_CAPCMP_LOW, 32'h5a);
    rdChk(ADDR_CAPCMP_HIGH, 32'h12);
    $display("test capture compare done");
    // Single pulse: one acquisition, then further pulses ignored
    wr(ADDR_TIMER_CONTROL, 32'h3);
    wr(ADDR_TIMER_GATE_CONTROL, 32'hd8);
    tick(4);
    c0 = count;
    pinA <= 1'b1;
    tick(20);
    pinA <= 1'b0;
    tick(4);
    `CHK((count - c0 >= 16'hf) && (count - c0 <= 16'h19), 1'b1)
    rdChk(ADDR_TIMER_GATE_CONTROL, 32'hd0);
    c0 = count;
    pinA <= 1'b1;
    tick(20);
    pinA <= 1'b0;
    tick(4);
    `CHK(count, c0)
    wr(ADDR_TIMER_GATE_CONTROL, 32'hd8);
    wr(ADDR_TIMER_GATE_CONTROL, 32'hd0);
    rdChk(ADDR_TIMER_GATE_CONTROL, 32'hd8);
    wr(ADDR_TIMER_GATE_CONTROL, 32'hc0);
    rdChk(ADDR_TIMER_GATE_CONTROL, 32'hc0);
    // Toggle: a one-cycle pin pulse opens the gate until the next rising edge
    wr(ADDR_TIMER_GATE_CONTROL, 32'he0);
    pinA <= 1'b1;
    tick(1);
    pinA <= 1'b0;
    delta(16'h14);
    wr(ADDR_TIMER_GATE_CONTROL, 32'hc0);
    delta(16'h0);
    // Toggle with single pulse: one full gate period, rise to rise, is counted
    wr(ADDR_TIMER_GATE_CONTROL, 32'hf8);
    tick(2);
    c0 = count;
    pinA <= 1'b1;
    tick(1);
    pinA <= 1'b0;
    tick(19);
    pinA <= 1'b1;
    tick(1);
    pinA <= 1'b0;
    tick(4);
    `CHK(count - c0, 16'h13)
    rdChk(ADDR_TIMER_GATE_CONTROL, 32'hf0);
    $display("test single pulse toggle done");
    end_sim();
  end
endmodule // gated_timer_sixteen_bit_tb
`default_nettype wire
